// *** bwf_regs.svh ***
// register offsets, field positions, reset values and timing counts of the bus wake filter
`ifndef BWF_REGS_SVH
`define BWF_REGS_SVH
// ----------------------------------------
// register word byte addresses
// ----------------------------------------
`define BWF_ADDR_CTRL 8'h00
`define BWF_ADDR_IDVAL 8'h04
`define BWF_ADDR_IDMASK 8'h08
`define BWF_ADDR_DATVAL_LO 8'h0C
`define BWF_ADDR_DATVAL_HI 8'h10
`define BWF_ADDR_DATMASK_LO 8'h14
`define BWF_ADDR_DATMASK_HI 8'h18
`define BWF_ADDR_TIMEOUT 8'h1C
`define BWF_ADDR_STATUS 8'h20
`define BWF_ADDR_IRQSTAT 8'h24
`define BWF_ADDR_IRQMASK 8'h28
// ----------------------------------------
// control fields
// ----------------------------------------
`define BWF_CTRL_WAKE_EN 0
`define BWF_CTRL_BIGEND 1
`define BWF_CTRL_RST 32'h0000_0000
// ----------------------------------------
// interrupt status bits
// ----------------------------------------
`define BWF_IRQ_MATCH 0
`define BWF_IRQ_START 1
`define BWF_IRQ_STOP 2
`define BWF_IRQ_W 3
// ----------------------------------------
// timing
// ----------------------------------------
`define BWF_CLK_HZ 40000000
`define BWF_BLINK_S 10
`define BWF_BLINK_CYC (`BWF_CLK_HZ * `BWF_BLINK_S)
`define BWF_BLINK_HALF_MS 50
`define BWF_BLINK_HALF_CYC (`BWF_CLK_HZ / 1000 * `BWF_BLINK_HALF_MS)
`define BWF_TIMEOUT_RST 32'h0262_5A00
`endif

// *** bwf_pkg.sv ***
// types shared by the bus wake filter
package bwf_pkg;
  typedef struct packed {
    logic valid;
    logic [28:0] ident;
    logic [63:0] data;
  } bwf_frame_s;

  typedef enum logic [2:0] {
    BWF_OFF = 3'h1,
    BWF_RUN_IGN = 3'h2,
    BWF_RUN_MSG = 3'h4
  } bwf_state_e;
endpackage : bwf_pkg

// *** bwf_wake_ctrl.sv ***
// wake-on-bus-message filter with ignition priority, keep-running timeout and boot indicator
`timescale 1ns/1ps
`include "bwf_regs.svh"
// Behaviour
// - big-endian control bit reverses byte order of payload before matching
// - match keeps device running; timeout without match shuts it down
// - only payload bits selected by the payload mask are compared
// - payload comparison is bitwise, gaps in mask allowed
// - payload filter covers all 64 data bits at any offset
// - rising ignition starts the device regardless of wake mode
// - ignition start stops only when ignition drops and no match active
// - after bus-message start indicator blinks fast while the device runs, for at most ten seconds
// - identifier bits selected by identifier mask must equal configured bits
// - all-zero mask matches every frame
// - bus-message start needs identifier and payload filters passing on same frame
module bwf_wake_ctrl
  import bwf_pkg::*;
#(
  parameter int BLINK_CYC = `BWF_BLINK_CYC,
  parameter int BLINK_HALF_CYC = `BWF_BLINK_HALF_CYC
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire bwf_frame_s rxFrame,
  input wire logic ignitionPin,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic powerHold,
  output logic shutdownReq,
  output logic wakeLed,
  output logic irq
);
  // elaboration check: blink counts the counters cannot serve
  if (BLINK_CYC < 1 || BLINK_HALF_CYC < 1 || BLINK_HALF_CYC > BLINK_CYC) begin : g_bad_blink
    $error("bwf_wake_ctrl: bad blink counts");
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // masked equality; a zero mask always passes
  function automatic logic maskMatch(input logic [63:0] val, input logic [63:0] ref_, input logic [63:0] msk);
    maskMatch = ((val ^ ref_) & msk) == 64'h0;
  endfunction : maskMatch

  function automatic logic [31:0] byteMerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      byteMerge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : byteMerge

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] ctrl_q;
  logic [28:0] idVal_q;
  logic [28:0] idMask_q;
  logic [63:0] datVal_q;
  logic [63:0] datMask_q;
  logic [31:0] timeout_q;
  logic [`BWF_IRQ_W-1:0] irqStat_q;
  logic [`BWF_IRQ_W-1:0] irqMask_q;
  logic ackPend_q;
  logic [31:0] rdData_q;

  logic ign1_q;
  logic ign2_q;
  logic ignPrev_q;
  bwf_state_e state_q;
  logic [31:0] keepCnt_q;
  logic [31:0] blinkCnt_q;
  logic [31:0] halfCnt_q;
  logic led_q;
  logic msgActive_q;
  logic shut_q;

  logic access;
  logic wrEn;
  logic rdEn;
  logic [63:0] payload;
  logic idOk;
  logic datOk;
  logic frameHit;
  logic ignRise;
  logic expire;
  logic evStart;
  logic evStop;

  assign access = (avs_read | avs_write) & ~ackPend_q;
  // writes land on the edge at which waitrequest is seen low
  assign wrEn = avs_write & ackPend_q;
  assign rdEn = avs_read & ~ackPend_q;
  // one wait cycle, then the answer
  assign avs_waitrequest = (avs_read | avs_write) & ~ackPend_q;

  // ----------------------------------------
  // frame filter
  // ----------------------------------------
  always_comb begin
    payload = rxFrame.data;
    if (ctrl_q[`BWF_CTRL_BIGEND]) begin
      for (int b = 0; b < 8; b++) begin
        payload[b*8 +: 8] = rxFrame.data[(7-b)*8 +: 8];
      end
    end
  end

  assign idOk = maskMatch({35'h0, rxFrame.ident}, {35'h0, idVal_q}, {35'h0, idMask_q});
  assign datOk = maskMatch(payload, datVal_q, datMask_q);
  assign frameHit = rxFrame.valid & idOk & datOk & ctrl_q[`BWF_CTRL_WAKE_EN];

  // ----------------------------------------
  // ignition synchroniser
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ign1_q <= 1'b0;
      ign2_q <= 1'b0;
      ignPrev_q <= 1'b0;
    end else begin
      ign1_q <= ignitionPin;
      ign2_q <= ign1_q;
      ignPrev_q <= ign2_q;
    end
  end
  assign ignRise = ign2_q & ~ignPrev_q;

  // ----------------------------------------
  // keep-running counter
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      keepCnt_q <= 32'h0;
      msgActive_q <= 1'b0;
    end else if (frameHit) begin
      keepCnt_q <= timeout_q;
      msgActive_q <= 1'b1;
    end else if (keepCnt_q > 32'h1) begin
      keepCnt_q <= keepCnt_q - 32'h1;
    end else begin
      keepCnt_q <= 32'h0;
      msgActive_q <= 1'b0;
    end
  end
  assign expire = msgActive_q & ~frameHit & (keepCnt_q <= 32'h1);

  // ----------------------------------------
  // power state machine
  // ----------------------------------------
  always_comb begin
    evStart = 1'b0;
    evStop = 1'b0;
    case (state_q)
      BWF_OFF: evStart = ignRise | frameHit;
      BWF_RUN_IGN: evStop = ~ign2_q & ~msgActive_q & ~frameHit;
      BWF_RUN_MSG: evStop = expire & ~ign2_q;
      default: evStop = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= BWF_OFF;
    end else begin
      case (state_q)
        BWF_OFF: begin
          if (ignRise) begin
            state_q <= BWF_RUN_IGN;
          end else if (frameHit) begin
            state_q <= BWF_RUN_MSG;
          end
        end
        BWF_RUN_IGN: begin
          if (evStop) begin
            state_q <= BWF_OFF;
          end
        end
        BWF_RUN_MSG: begin
          if (ignRise) begin
            state_q <= BWF_RUN_IGN;
          end else if (evStop) begin
            state_q <= BWF_OFF;
          end
        end
        default: state_q <= BWF_OFF;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      shut_q <= 1'b0;
    end else begin
      shut_q <= evStop;
    end
  end

  assign powerHold = (state_q != BWF_OFF);
  assign shutdownReq = shut_q;

  // ----------------------------------------
  // boot indicator blink
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      blinkCnt_q <= 32'h0;
      halfCnt_q <= 32'h0;
      led_q <= 1'b0;
    end else if (state_q == BWF_OFF && frameHit && !ignRise) begin
      blinkCnt_q <= 32'(BLINK_CYC);
      halfCnt_q <= 32'(BLINK_HALF_CYC);
      led_q <= 1'b1;
    end else if (blinkCnt_q != 32'h0 && state_q != BWF_OFF) begin
      blinkCnt_q <= blinkCnt_q - 32'h1;
      if (halfCnt_q <= 32'h1) begin
        halfCnt_q <= 32'(BLINK_HALF_CYC);
        led_q <= ~led_q;
      end else begin
        halfCnt_q <= halfCnt_q - 32'h1;
      end
    end else begin
      blinkCnt_q <= 32'h0;
      led_q <= 1'b0;
    end
  end
  assign wakeLed = led_q;

  // ----------------------------------------
  // bus slave: configuration writes
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= `BWF_CTRL_RST;
      idVal_q <= 29'h0;
      idMask_q <= 29'h0;
      datVal_q <= 64'h0;
      datMask_q <= 64'h0;
      timeout_q <= `BWF_TIMEOUT_RST;
      irqMask_q <= '0;
    end else if (wrEn) begin
      if (avs_address == `BWF_ADDR_CTRL) begin
        ctrl_q <= byteMerge(ctrl_q, avs_writedata, avs_byteenable) & 32'h0000_0003;
      end else if (avs_address == `BWF_ADDR_IDVAL) begin
        idVal_q <= 29'(byteMerge({3'h0, idVal_q}, avs_writedata, avs_byteenable));
      end else if (avs_address == `BWF_ADDR_IDMASK) begin
        idMask_q <= 29'(byteMerge({3'h0, idMask_q}, avs_writedata, avs_byteenable));
      end else if (avs_address == `BWF_ADDR_DATVAL_LO) begin
        datVal_q[31:0] <= byteMerge(datVal_q[31:0], avs_writedata, avs_byteenable);
      end else if (avs_address == `BWF_ADDR_DATVAL_HI) begin
        datVal_q[63:32] <= byteMerge(datVal_q[63:32], avs_writedata, avs_byteenable);
      end else if (avs_address == `BWF_ADDR_DATMASK_LO) begin
        datMask_q[31:0] <= byteMerge(datMask_q[31:0], avs_writedata, avs_byteenable);
      end else if (avs_address == `BWF_ADDR_DATMASK_HI) begin
        datMask_q[63:32] <= byteMerge(datMask_q[63:32], avs_writedata, avs_byteenable);
      end else if (avs_address == `BWF_ADDR_TIMEOUT) begin
        timeout_q <= byteMerge(timeout_q, avs_writedata, avs_byteenable);
      end else if (avs_address == `BWF_ADDR_IRQMASK) begin
        irqMask_q <= avs_byteenable[0] ? avs_writedata[`BWF_IRQ_W-1:0] : irqMask_q;
      end
    end
  end

  // ----------------------------------------
  // sticky event status, cleared by read; a new event wins
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqStat_q <= '0;
    end else begin
      irqStat_q <= ((rdEn && avs_address == `BWF_ADDR_IRQSTAT) ? '0 : irqStat_q)
        | {evStop, (state_q == BWF_OFF) & evStart, frameHit};
    end
  end
  assign irq = |(irqStat_q & irqMask_q);

  // ----------------------------------------
  // bus slave: read data and acknowledge
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ackPend_q <= 1'b0;
      rdData_q <= 32'h0;
    end else begin
      ackPend_q <= access;
      if (rdEn) begin
        if (avs_address == `BWF_ADDR_CTRL) begin
          rdData_q <= ctrl_q;
        end else if (avs_address == `BWF_ADDR_IDVAL) begin
          rdData_q <= {3'h0, idVal_q};
        end else if (avs_address == `BWF_ADDR_IDMASK) begin
          rdData_q <= {3'h0, idMask_q};
        end else if (avs_address == `BWF_ADDR_DATVAL_LO) begin
          rdData_q <= datVal_q[31:0];
        end else if (avs_address == `BWF_ADDR_DATVAL_HI) begin
          rdData_q <= datVal_q[63:32];
        end else if (avs_address == `BWF_ADDR_DATMASK_LO) begin
          rdData_q <= datMask_q[31:0];
        end else if (avs_address == `BWF_ADDR_DATMASK_HI) begin
          rdData_q <= datMask_q[63:32];
        end else if (avs_address == `BWF_ADDR_TIMEOUT) begin
          rdData_q <= timeout_q;
        end else if (avs_address == `BWF_ADDR_STATUS) begin
          rdData_q <= {25'h0, wakeLed, msgActive_q, ign2_q, powerHold, 3'(state_q)};
        end else if (avs_address == `BWF_ADDR_IRQSTAT) begin
          rdData_q <= {29'h0, irqStat_q};
        end else if (avs_address == `BWF_ADDR_IRQMASK) begin
          rdData_q <= {29'h0, irqMask_q};
        end else begin
          rdData_q <= 32'h0; // unmapped reads zero
        end
      end
    end
  end
  assign avs_readdata = rdData_q;
endmodule : bwf_wake_ctrl

// *** bwf_bus_node.sv ***
// model of the far bus nodes and the ignition terminal
`timescale 1ns/1ps
module bwf_bus_node
  import bwf_pkg::*;
(
  input wire logic clk,
  output bwf_frame_s frame,
  output logic ign
);
  // idle bus and ignition off from time zero
  initial begin
    frame = '0;
    ign = 1'b0;
  end
  // one-cycle frame strobe; fields flip once it drops so stale data never matches
  task automatic send(input logic [28:0] fi, input logic [63:0] fd);
    frame <= {1'b1, fi, fd};
    @(posedge clk);
    frame <= {1'b0, ~fi, ~fd};
  endtask : send
  // ignition terminal level
  task automatic setIgn(input logic v);
    ign <= v;
  endtask : setIgn
endmodule : bwf_bus_node

// *** bwf_wake_chk.sv ***
// port-level assertions of the bus wake filter
`timescale 1ns/1ps
module bwf_wake_chk
  import bwf_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire bwf_frame_s rxFrame,
  input wire logic ignitionPin,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic powerHold,
  input wire logic shutdownReq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // bus handshake: at most one wait cycle, readdata only moves on a taken read
  a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest longer than one cycle");
  a_wait_req: assert property (avs_waitrequest |-> avs_read || avs_write)
    else $error("waitrequest without a request");
  a_rd_hold: assert property ($changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
    else $error("readdata moved without a read");
  // run and stop decisions
  a_ign_start: assert property (ignitionPin [*5] |-> powerHold)
    else $error("ignition did not start the run");
  a_ign_hold: assert property (ignitionPin [*3] ##0 powerHold |=> powerHold)
    else $error("run dropped while ignition high");
  a_stop_pulse: assert property ($fell(powerHold) |-> ##[0:1] shutdownReq)
    else $error("no shutdown request after stop");
  a_stop_off: assert property (shutdownReq |-> !powerHold ##1 !shutdownReq)
    else $error("shutdown request while running or too long");
  a_run_cause: assert property ($rose(powerHold) |-> $past(rxFrame.valid) || $past(ignitionPin, 2))
    else $error("run started without frame or ignition");
endmodule : bwf_wake_chk

// *** tb.sv ***
// self-checking bench of the bus wake filter
`timescale 1ns/1ps
`include "bwf_regs.svh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb;
  import bwf_pkg::*;
  localparam int TMO = 20;
  logic clk, arstN, rd, wr, waitReq, hold, sdReq, led, irq, ign, m, be;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, q;
  logic [28:0] idv, idm, id;
  logic [63:0] dv, dm, d;
  bwf_frame_s frame;
  int miscompares, checked, f, i;
  // filter table: value, mask, first probe value, bit offset
  logic [63:0] tv [3] = '{64'd16, 64'd18, 64'd384 << 40};
  logic [63:0] tm [3] = '{64'd24, 64'd18, 64'hFF80 << 40};
  int tb0 [3] = '{15, 15, 370};
  int ts [3] = '{0, 0, 40};
  bwf_wake_ctrl #(.BLINK_CYC(200), .BLINK_HALF_CYC(10)) u_dut (.core_clk(clk), .arst_n(arstN), .rxFrame(frame),
    .ignitionPin(ign), .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(waitReq), .powerHold(hold),
    .shutdownReq(sdReq), .wakeLed(led), .irq(irq));
  bwf_bus_node u_node (.clk(clk), .frame(frame), .ign(ign));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // expected start decision of one frame
  function automatic logic hit(input logic [28:0] fi, input logic [63:0] fd);
    logic [63:0] x;
    x = fd;
    if (be) x = {<<8{fd}};
    return (((fi ^ idv) & idm) == 0) && (((x ^ dv) & dm) == 0);
  endfunction : hit
  // one bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= wd;
    do begin
      @(negedge clk);
      n++;
    end while (waitReq !== 1'b0 && n < 50);
    if (n == 50) miscompares++;
    @(posedge clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  // send one frame, check start, interrupt and timed stop
  task automatic probe(input logic [63:0] fd);
    int p;
    p = 0;
    m = hit(id, fd);
    u_node.send(id, fd);
    @(negedge clk);
    `CHK("powerHold", m, hold)
    `CHK("irq", m, irq)
    if (m) `CHK("wakeLed", 1'b1, led)
    bus(1'b0, `BWF_ADDR_IRQSTAT, 32'h0);
    `CHK("irqStat", {29'h0, 1'b0, m, m}, q)
    `CHK("irqCleared", 1'b0, irq)
    repeat (TMO + 4) begin
      @(negedge clk);
      p += sdReq;
    end
    `CHK("stopped", 1'b0, hold)
    `CHK("stopPulse", int'(m), p)
    bus(1'b0, `BWF_ADDR_IRQSTAT, 32'h0);
    `CHK("stopBit", {29'h0, m, 2'b00}, q)
  endtask : probe
  // verdict and end of run
  task automatic end_of_test();
    if (miscompares == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
  // main sequence
  initial begin
    void'($urandom(97810));
    arstN = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    be = 1'b0;
    miscompares = 0;
    checked = 0;
    repeat (10) @(posedge clk);
    arstN <= 1'b1;
    bus(1'b0, `BWF_ADDR_CTRL, 32'h0);
    `CHK("ctrlReset", `BWF_CTRL_RST, q)
    bus(1'b0, `BWF_ADDR_TIMEOUT, 32'h0);
    `CHK("timeoutReset", `BWF_TIMEOUT_RST, q)
    bus(1'b0, 8'h3C, 32'h0);
    `CHK("unmapped", 32'h0, q)
    bus(1'b1, `BWF_ADDR_TIMEOUT, TMO);
    bus(1'b1, `BWF_ADDR_IRQMASK, 32'h1);
    idv = 29'd100;
    idm = 29'd127;
    bus(1'b1, `BWF_ADDR_IDVAL, 32'd100);
    bus(1'b1, `BWF_ADDR_IDMASK, 32'd127);
    // payload filters over boundary values, identifier sometimes wrong
    for (f = 0; f < 3; f++) begin
      be = (f == 2);
      dv = tv[f];
      dm = tm[f];
      bus(1'b1, `BWF_ADDR_CTRL, {30'h0, be, 1'b1});
      bus(1'b1, `BWF_ADDR_DATVAL_LO, dv[31:0]);
      bus(1'b1, `BWF_ADDR_DATVAL_HI, dv[63:32]);
      bus(1'b1, `BWF_ADDR_DATMASK_LO, dm[31:0]);
      bus(1'b1, `BWF_ADDR_DATMASK_HI, dm[63:32]);
      for (i = 0; i < 18; i++) begin
        id = 29'($urandom);
        if (i % 4 != 0) id[6:0] = 7'd100;
        d = ({$urandom, $urandom} & ~dm) | ((64'(tb0[f] + i) << ts[f]) & dm);
        if (be) d = {<<8{d}};
        probe(d);
      end
    end
    // hits closer than the timeout keep the run alive
    d = {<<8{dv}};
    repeat (4) begin
      u_node.send(29'd100, d);
      repeat (TMO - 6) @(posedge clk);
    end
    `CHK("keepAlive", 1'b1, hold)
    repeat (10) @(posedge clk);
    `CHK("keepExpired", 1'b0, hold)
    // all-zero masks accept any frame
    idm = 29'h0;
    dm = 64'h0;
    bus(1'b1, `BWF_ADDR_IDMASK, 32'h0);
    bus(1'b1, `BWF_ADDR_DATMASK_LO, 32'h0);
    bus(1'b1, `BWF_ADDR_DATMASK_HI, 32'h0);
    bus(1'b0, `BWF_ADDR_IRQSTAT, 32'h0);
    id = 29'($urandom);
    probe({$urandom, $urandom});
    // wake disabled: a matching frame must not start the run
    bus(1'b1, `BWF_ADDR_CTRL, 32'h0);
    u_node.send(29'd100, 64'h0);
    @(negedge clk);
    `CHK("wakeOff", 1'b0, hold)
    bus(1'b1, `BWF_ADDR_CTRL, 32'h1);
    // ignition start with message wake selected, then drop under a live match
    repeat (250) @(posedge clk);
    u_node.setIgn(1'b1);
    repeat (6) @(posedge clk);
    `CHK("ignRun", 1'b1, hold)
    `CHK("ignLed", 1'b0, led)
    bus(1'b0, `BWF_ADDR_STATUS, 32'h0);
    `CHK("ignStatus", 32'h0000_001A, q)
    u_node.send(29'd100, 64'h0);
    u_node.setIgn(1'b0);
    repeat (6) @(posedge clk);
    `CHK("msgHold", 1'b1, hold)
    repeat (TMO) @(posedge clk);
    `CHK("ignStop", 1'b0, hold)
    end_of_test();
  end
endmodule : tb
bind bwf_wake_ctrl bwf_wake_chk u_chk (.core_clk(core_clk), .arst_n(arst_n), .rxFrame(rxFrame),
  .ignitionPin(ignitionPin), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .powerHold(powerHold), .shutdownReq(shutdownReq));
